// [design/fpp_ctrl.v]
// Flash program/erase sequencer with unlock keys and option-bit protection
//
// Notes on behaviour
// - Program one byte or a latched row of up to 32 bytes at once.
// - Sector erase touches only addresses inside that sector.
// - Socket and serial modes may change sectors 0, 1, options, EEPROM.
// - In-application mode blocks sector 0 and the option row.
// - Reset pin low plus clock pulse burst enters serial mode.
// - Serial mode boots from the system-memory vector instead.
// - Serial session: enter mode, load driver to RAM, run it.
// - 38-pulse entry forces the internal RC clock source.
// - Any reset returns serial clock pin to input with pull-up.
// - Read-out protection hides contents from socket/serial reads and refuses flash writes.
// - Removing read-out protection first erases flash and EEPROM.
// - Write protection refuses flash program/erase, EEPROM stays writable.
// - Write protection once set is cleared only by system reset.
// - Read-out and write protection are separate, independent bits.
// - Keys 56h then AEh must precede any sector erase or program; ROP removal erases without them.
// - Control/status register resets to 00h.
`timescale 1ns/1ps
`default_nettype none
`include "fpp_map.vh"

module fpp_ctrl #(
  parameter [15:0] VEC_USER   = 16'hFFFE, // Normal reset vector
  parameter [15:0] VEC_SYSMEM = 16'h1000  // System memory vector
) (
  input  wire        clock,             // System clock, 200 MHz
  input  wire        sys_rst,           // Synchronous reset, active high
  input  wire [2:0]  reg_addr,          // Register index
  input  wire [7:0]  reg_wdata,         // Register write data
  input  wire        reg_wr,            // Write strobe
  input  wire        reg_rd,            // Read strobe
  output reg  [7:0]  reg_rdata,         // Read data, cycle after strobe
  input  wire        rst_pin_n,         // Reset pin, active low, async
  input  wire        prog_serial_clock_pin_i,  // Clock pin level
  output wire        prog_serial_clock_pin_o,  // Clock pin drive value
  output wire        prog_serial_clock_pin_oe, // Clock pin drive enable
  output wire        prog_serial_clock_pullup, // Clock pin pull-up on
  input  wire        socket_mode_pin,   // Tool socket strap, async
  output wire        in_circuit_comm,   // Serial comm mode active
  output wire        rc_clock_forced,   // Internal RC forced
  output reg  [15:0] boot_vector_r,     // Vector fetched at reset
  output wire        flash_busy,        // Program/erase running
  output reg         eeprom_mass_erase_r, // EEPROM erase pulse
  output wire        eeprom_readout_block, // EEPROM hidden externally
  output wire        eeprom_write_enable   // EEPROM may be written
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_WAIT  = 3'h1;
  localparam [2:0] ST_PROG  = 3'h2;
  localparam [2:0] ST_ERASE = 3'h3;
  localparam [1:0] KEY_LOCK = 2'h0;
  localparam [1:0] KEY_ONE  = 2'h1;
  localparam [1:0] KEY_OPEN = 2'h2;
  localparam integer PROG_CYC  = `FPP_PROG_CYCLES;
  localparam integer ERASE_CYC = `FPP_ERASE_CYCLES;

  reg  [7:0]  flash_mem [0:`FPP_FLASH_BYTES-1];
  reg  [7:0]  lat_data  [0:`FPP_ROW_BYTES-1];
  reg  [31:0] lat_valid_r;
  reg  [6:0]  row_r;
  reg  [2:0]  state_r;
  reg  [1:0]  key_r;
  reg  [11:0] timer_r;
  reg  [11:0] idx_r;
  reg  [11:0] end_r;
  reg         erase_op_r;
  reg         mass_r;
  reg  [7:0]  flash_ctrl_status_r;
  reg  [11:0] addr_r;
  reg         rop_r;
  reg         wp_r;
  reg  [1:0]  s0sz_r;
  reg         err_r;
  reg  [1:0]  pincfg_r;
  reg         sock_m_r;
  reg         sock_s_r;
  reg         mem_we;
  reg  [11:0] mem_wa;
  reg  [7:0]  mem_wd;
  wire        pin_rst_n_s;
  wire        icc_act;
  wire        dev_rst;
  wire        external;
  wire        in_app_prog;
  wire [11:0] s0_end;
  wire        idle;

  // ----------------------------------------------------------------------
  // Access check shared by program and erase
  // ----------------------------------------------------------------------
  function ok_to_write;
    input [11:0] a;
    input [11:0] last0;
    input        rop;
    input        wp;
    input        in_app;
    begin
      ok_to_write = !rop && !wp && !(in_app && a <= last0);
    end
  endfunction

  fpp_entry_detect u_entry (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .rst_pin_n    (rst_pin_n),
    .sclk_pin_i   (prog_serial_clock_pin_i),
    .pin_rst_n_s  (pin_rst_n_s),
    .icc_active_r (icc_act),
    .rc_forced_r  (rc_clock_forced)
  );

  // Pin reset resets logic but not the nonvolatile option state
  assign dev_rst         = sys_rst | ~pin_rst_n_s;
  assign in_circuit_comm = icc_act;
  assign external        = sock_s_r | icc_act;
  assign in_app_prog             = ~external;
  assign s0_end          = (`FPP_S0_BASE << s0sz_r) - 12'h001;
  assign idle            = (state_r == ST_IDLE);
  assign flash_busy      = ~idle;

  assign prog_serial_clock_pin_oe = pincfg_r[`FPP_PIN_OE];
  assign prog_serial_clock_pin_o  = pincfg_r[`FPP_PIN_OUT];
  assign prog_serial_clock_pullup = ~pincfg_r[`FPP_PIN_OE];
  assign eeprom_readout_block     = rop_r & external;
  assign eeprom_write_enable      = ~rop_r & ~mass_r;

  // ----------------------------------------------------------------------
  // Strap synchroniser and boot vector
  // ----------------------------------------------------------------------
  always @(posedge clock) begin
    if (sys_rst) begin
      sock_m_r      <= 1'b0;
      sock_s_r      <= 1'b0;
      boot_vector_r <= VEC_USER;
    end else begin
      sock_m_r      <= socket_mode_pin;
      sock_s_r      <= sock_m_r;
      // Driver download and run happen from system memory code
      boot_vector_r <= icc_act ? VEC_SYSMEM : VEC_USER;
    end
  end

  // ----------------------------------------------------------------------
  // Array write port
  // ----------------------------------------------------------------------
  always @* begin
    mem_we = 1'b0;
    mem_wa = idx_r;
    mem_wd = `FPP_ERASED;
    if (state_r == ST_PROG) begin
      mem_we = lat_valid_r[idx_r[4:0]];
      mem_wa = {row_r, idx_r[4:0]};
      mem_wd = lat_data[idx_r[4:0]];
    end else if (state_r == ST_ERASE) begin
      mem_we = 1'b1;
    end
  end

  always @(posedge clock) begin
    if (mem_we)
      flash_mem[mem_wa] <= mem_wd;
    if (reg_wr && reg_addr == `FPP_REG_DATA && idle &&
        flash_ctrl_status_r[`FPP_FLASH_CTRL_STATUS_LAT])
      lat_data[addr_r[4:0]] <= reg_wdata;
  end

  // ----------------------------------------------------------------------
  // Pin configuration, cleared by every reset
  // ----------------------------------------------------------------------
  always @(posedge clock) begin
    if (dev_rst)
      pincfg_r <= 2'h0;
    else if (reg_wr && reg_addr == `FPP_REG_PINCFG)
      pincfg_r <= reg_wdata[1:0];
  end

  // ----------------------------------------------------------------------
  // Option bits: survive pin reset; system reset clears them, a finished mass erase clears ROP
  // ----------------------------------------------------------------------
  always @(posedge clock) begin
    if (sys_rst) begin
      rop_r  <= 1'b0;
      wp_r   <= 1'b0;
      s0sz_r <= 2'h0;
    end else if (mass_r && state_r == ST_ERASE && idx_r == end_r) begin
      rop_r <= 1'b0;
    end else if (reg_wr && reg_addr == `FPP_REG_OPTION && idle &&
                 external && !mass_r) begin
      if (!(rop_r && !reg_wdata[`FPP_OPT_ROP]))
        rop_r <= reg_wdata[`FPP_OPT_ROP];
      wp_r <= wp_r | reg_wdata[`FPP_OPT_WP];
      if (!wp_r)
        s0sz_r <= reg_wdata[`FPP_OPT_S0SZ_LO+1:`FPP_OPT_S0SZ_LO];
    end
  end

  // ----------------------------------------------------------------------
  // Unlock keys, control register and sequencer
  // ----------------------------------------------------------------------
  always @(posedge clock) begin
    if (dev_rst) begin
      state_r             <= ST_IDLE;
      key_r               <= KEY_LOCK;
      flash_ctrl_status_r              <= `FPP_FLASH_CTRL_STATUS_RESET;
      timer_r             <= 12'h000;
      idx_r               <= 12'h000;
      end_r               <= 12'h000;
      erase_op_r          <= 1'b0;
      mass_r              <= 1'b0;
      addr_r              <= 12'h000;
      row_r               <= 7'h00;
      lat_valid_r         <= 32'h0000_0000;
      err_r               <= 1'b0;
      eeprom_mass_erase_r <= 1'b0;
    end else begin
      eeprom_mass_erase_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (reg_wr && reg_addr == `FPP_REG_ADDR_LO)
            addr_r[7:0] <= reg_wdata;
          if (reg_wr && reg_addr == `FPP_REG_ADDR_HI)
            addr_r[11:8] <= reg_wdata[3:0];
          if (reg_wr && reg_addr == `FPP_REG_STATUS)
            err_r <= 1'b0;
          if (reg_wr && reg_addr == `FPP_REG_DATA &&
              flash_ctrl_status_r[`FPP_FLASH_CTRL_STATUS_LAT]) begin
            lat_valid_r[addr_r[4:0]] <= 1'b1;
            row_r                    <= addr_r[11:5];
            addr_r[4:0]              <= addr_r[4:0] + 5'h01;
          end
          if (reg_wr && reg_addr == `FPP_REG_OPTION && external &&
              rop_r && !reg_wdata[`FPP_OPT_ROP]) begin
            mass_r              <= 1'b1;
            erase_op_r          <= 1'b1;
            idx_r               <= 12'h000;
            end_r               <= `FPP_LAST_ADDR;
            timer_r             <= ERASE_CYC[11:0];
            eeprom_mass_erase_r <= 1'b1;
            state_r             <= ST_WAIT;
          end
          if (reg_wr && reg_addr == `FPP_REG_FLASH_CTRL_STATUS) begin
            case (key_r)
              KEY_LOCK: begin
                if (reg_wdata == `FPP_KEY1)
                  key_r <= KEY_ONE;
              end
              KEY_ONE: begin
                key_r <= (reg_wdata == `FPP_KEY2) ? KEY_OPEN
                                                  : KEY_LOCK;
              end
              KEY_OPEN: begin
                flash_ctrl_status_r <= reg_wdata & `FPP_FLASH_CTRL_STATUS_MASK;
                if (reg_wdata[`FPP_FLASH_CTRL_STATUS_PGM]) begin
                  if (reg_wdata[`FPP_FLASH_CTRL_STATUS_ERS]) begin
                    if (ok_to_write(addr_r, s0_end, rop_r, wp_r, in_app_prog)) begin
                      erase_op_r <= 1'b1;
                      // Sector bounds only: other sectors untouched
                      idx_r   <= (addr_r <= s0_end) ? 12'h000
                                                    : s0_end + 12'h001;
                      end_r   <= (addr_r <= s0_end) ? s0_end
                                                    : `FPP_LAST_ADDR;
                      timer_r <= ERASE_CYC[11:0];
                      state_r <= ST_WAIT;
                    end else begin
                      err_r  <= 1'b1;
                      flash_ctrl_status_r <= `FPP_FLASH_CTRL_STATUS_RESET;
                      key_r  <= KEY_LOCK;
                    end
                  end else if (ok_to_write({row_r, 5'h00}, s0_end,
                                           rop_r, wp_r, in_app_prog)) begin
                    erase_op_r <= 1'b0;
                    idx_r      <= 12'h000;
                    end_r      <= 12'h01F;
                    timer_r    <= PROG_CYC[11:0];
                    state_r    <= ST_WAIT;
                  end else begin
                    err_r       <= 1'b1;
                    flash_ctrl_status_r      <= `FPP_FLASH_CTRL_STATUS_RESET;
                    key_r       <= KEY_LOCK;
                    lat_valid_r <= 32'h0000_0000;
                  end
                end
              end
              default: key_r <= KEY_LOCK;
            endcase
          end
        end
        ST_WAIT: begin
          // Array cells need the full pulse before any byte lands
          if (timer_r == 12'h001)
            state_r <= erase_op_r ? ST_ERASE : ST_PROG;
          timer_r <= timer_r - 12'h001;
        end
        ST_PROG, ST_ERASE: begin
          idx_r <= idx_r + 12'h001;
          if (idx_r == end_r) begin
            state_r     <= ST_IDLE;
            mass_r      <= 1'b0;
            flash_ctrl_status_r      <= `FPP_FLASH_CTRL_STATUS_RESET;
            key_r       <= KEY_LOCK;
            lat_valid_r <= 32'h0000_0000;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  always @(posedge clock) begin
    if (dev_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `FPP_REG_FLASH_CTRL_STATUS:    reg_rdata <= flash_ctrl_status_r;
        `FPP_REG_ADDR_LO: reg_rdata <= addr_r[7:0];
        `FPP_REG_ADDR_HI: reg_rdata <= {4'h0, addr_r[11:8]};
        `FPP_REG_DATA:
          reg_rdata <= (rop_r && external) ? 8'h00
                                           : flash_mem[addr_r];
        `FPP_REG_OPTION:  reg_rdata <= {4'h0, s0sz_r, wp_r, rop_r};
        `FPP_REG_STATUS:
          reg_rdata <= {1'b0, rc_clock_forced, sock_s_r, icc_act,
                        err_r, key_r == KEY_OPEN, mass_r, ~idle};
        `FPP_REG_PINCFG:  reg_rdata <= {6'h00, pincfg_r};
        default:          reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// [design/fpp_map.vh]
// Register map, field positions and timing constants of the flash controller
`ifndef FPP_MAP_VH
`define FPP_MAP_VH

// ----------------------------------------------------------------------
// Register indices on the plain register port
// ----------------------------------------------------------------------
`define FPP_REG_FLASH_CTRL_STATUS      3'h0
`define FPP_REG_ADDR_LO   3'h1
`define FPP_REG_ADDR_HI   3'h2
`define FPP_REG_DATA      3'h3
`define FPP_REG_OPTION    3'h4
`define FPP_REG_STATUS    3'h5
`define FPP_REG_PINCFG    3'h6

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define FPP_FLASH_CTRL_STATUS_PGM      0
`define FPP_FLASH_CTRL_STATUS_LAT      1
`define FPP_FLASH_CTRL_STATUS_ERS      2
`define FPP_FLASH_CTRL_STATUS_MASK     8'h07
`define FPP_FLASH_CTRL_STATUS_RESET    8'h00
`define FPP_OPT_ROP       0
`define FPP_OPT_WP        1
`define FPP_OPT_S0SZ_LO   2
`define FPP_PIN_OE        0
`define FPP_PIN_OUT       1
`define FPP_KEY1          8'h56
`define FPP_KEY2          8'hAE
`define FPP_ERASED        8'hFF

// ----------------------------------------------------------------------
// Array geometry and entry sequence
// ----------------------------------------------------------------------
`define FPP_FLASH_BYTES   4096
`define FPP_ROW_BYTES     32
`define FPP_LAST_ADDR     12'hFFF
`define FPP_S0_BASE       12'h200
`define FPP_PULSES_RC     6'h26
`define FPP_PULSES_EXT    6'h23

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define FPP_CLK_PERIOD_NS 5
`define FPP_PROG_TIME_NS  5000
`define FPP_ERASE_TIME_NS 20000
`define FPP_PROG_CYCLES   (`FPP_PROG_TIME_NS / `FPP_CLK_PERIOD_NS)
`define FPP_ERASE_CYCLES  (`FPP_ERASE_TIME_NS / `FPP_CLK_PERIOD_NS)

`endif

// [design/fpp_entry_detect.v]
// Serial-mode entry detector: counts clock pulses while the reset pin is low
`timescale 1ns/1ps
`default_nettype none
`include "fpp_map.vh"

module fpp_entry_detect (
  input  wire       clock,        // System clock
  input  wire       sys_rst,      // Synchronous reset, active high
  input  wire       rst_pin_n,    // Reset pin from the tool, async
  input  wire       sclk_pin_i,   // Serial clock pin level, async
  output wire       pin_rst_n_s,  // Synchronised reset pin
  output reg        icc_active_r, // Serial communication mode entered
  output reg        rc_forced_r   // Internal RC forced as clock source
);

  reg       rst_m_r;
  reg       rst_s_r;
  reg       rst_d_r;
  reg       clk_m_r;
  reg       clk_s_r;
  reg       clk_d_r;
  reg [5:0] pulse_r;

  assign pin_rst_n_s = rst_s_r;

  // --------------------------------------------------------------------
  // Synchronisers; the third stage only feeds edge detection
  // --------------------------------------------------------------------
  always @(posedge clock) begin
    if (sys_rst) begin
      rst_m_r <= 1'b1;
      rst_s_r <= 1'b1;
      rst_d_r <= 1'b1;
      clk_m_r <= 1'b1;
      clk_s_r <= 1'b1;
      clk_d_r <= 1'b1;
    end else begin
      rst_m_r <= rst_pin_n;
      rst_s_r <= rst_m_r;
      rst_d_r <= rst_s_r;
      clk_m_r <= sclk_pin_i;
      clk_s_r <= clk_m_r;
      clk_d_r <= clk_s_r;
    end
  end

  // --------------------------------------------------------------------
  // Pulse count and decision at reset release
  // --------------------------------------------------------------------
  always @(posedge clock) begin
    if (sys_rst) begin
      pulse_r      <= 6'h00;
      icc_active_r <= 1'b0;
      rc_forced_r  <= 1'b0;
    end else if (!rst_s_r) begin
      icc_active_r <= 1'b0;
      rc_forced_r  <= 1'b0;
      // Saturate so a long burst cannot wrap onto a valid count
      if (clk_s_r && !clk_d_r && pulse_r != 6'h3F)
        pulse_r <= pulse_r + 6'h01;
    end else if (!rst_d_r) begin
      icc_active_r <= (pulse_r == `FPP_PULSES_RC) ||
                      (pulse_r == `FPP_PULSES_EXT);
      rc_forced_r  <= (pulse_r == `FPP_PULSES_RC);
      pulse_r      <= 6'h00;
    end
  end

endmodule
`default_nettype wire

// [test/fpp_ctrl_properties.sv]
// Concurrent checks on the flash controller's top-level ports
`timescale 1ns/1ps
`default_nettype none
module fpp_ctrl_properties #(
  parameter [15:0] VEC_SYSMEM = 16'h1000 // Serial-mode boot vector
) (
  input wire logic        clock,                    // System clock
  input wire logic        sys_rst,                  // Synchronous reset
  input wire logic        rst_pin_n,                // Reset pin
  input wire logic        prog_serial_clock_pin_oe, // Clock pin enable
  input wire logic        prog_serial_clock_pullup, // Clock pin pull-up
  input wire logic        in_circuit_comm,          // Serial mode
  input wire logic        rc_clock_forced,          // RC forced
  input wire logic [15:0] boot_vector_r,            // Boot vector
  input wire logic        flash_busy,               // Sequencer busy
  input wire logic        eeprom_mass_erase_r,      // Mass erase pulse
  input wire logic        eeprom_readout_block,     // EEPROM hidden
  input wire logic        eeprom_write_enable       // EEPROM writable
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ------------------------------------------------------------------
  // Busy length counter
  // ------------------------------------------------------------------
  // Shortest operation is one byte: the full program wait still applies
  logic [15:0] busy_cnt_r;
  always @(posedge clock) begin
    if (sys_rst || !flash_busy) begin
      busy_cnt_r <= 16'h0000;
    end else begin
      busy_cnt_r <= busy_cnt_r + 16'h0001;
    end
  end
  a_pin_reset_input: assert property ((!rst_pin_n) [*3] |=>
    !prog_serial_clock_pin_oe && prog_serial_clock_pullup)
    else $error("clock pin not returned to input after reset");
  a_pullup_follows_oe: assert property (
    prog_serial_clock_pullup == !prog_serial_clock_pin_oe)
    else $error("pull-up not the inverse of drive enable");
  a_boot_sysmem: assert property (in_circuit_comm &&
    $past(in_circuit_comm) |-> boot_vector_r == VEC_SYSMEM)
    else $error("serial mode without system-memory vector");
  a_rc_needs_comm: assert property (rc_clock_forced |-> in_circuit_comm)
    else $error("RC forced outside serial mode");
  a_entry_after_release: assert property ($rose(in_circuit_comm) |->
    $past(rst_pin_n, 2) && rst_pin_n)
    else $error("serial mode entered while reset pin low");
  a_busy_min_length: assert property ($fell(flash_busy) |->
    busy_cnt_r >= 16'h03E8)
    else $error("flash operation shorter than program time");
  a_mass_blocks_we: assert property ($rose(eeprom_mass_erase_r) |->
    !eeprom_write_enable)
    else $error("EEPROM writable during mass erase");
  a_mass_one_pulse: assert property (eeprom_mass_erase_r |=>
    !eeprom_mass_erase_r)
    else $error("mass erase pulse longer than one cycle");
  a_block_no_write: assert property (eeprom_readout_block |->
    !eeprom_write_enable)
    else $error("protected EEPROM still writable");
  c_entry_rc: cover property (in_circuit_comm && rc_clock_forced);
  c_entry_ext: cover property (in_circuit_comm && !rc_clock_forced);
  c_op_done: cover property ($fell(flash_busy));
  c_mass: cover property (eeprom_mass_erase_r);
endmodule
bind fpp_ctrl fpp_ctrl_properties #(.VEC_SYSMEM(VEC_SYSMEM)) u_props (
  .clock(clock), .sys_rst(sys_rst), .rst_pin_n(rst_pin_n),
  .prog_serial_clock_pin_oe(prog_serial_clock_pin_oe),
  .prog_serial_clock_pullup(prog_serial_clock_pullup),
  .in_circuit_comm(in_circuit_comm), .rc_clock_forced(rc_clock_forced),
  .boot_vector_r(boot_vector_r), .flash_busy(flash_busy),
  .eeprom_mass_erase_r(eeprom_mass_erase_r),
  .eeprom_readout_block(eeprom_readout_block),
  .eeprom_write_enable(eeprom_write_enable));
`default_nettype wire

// [test/fpp_tool_model.sv]
// Behavioural programming tool: reset pin frame with clock pulse burst
`timescale 1ns/1ps
`default_nettype none
module fpp_tool_model (
  input  wire logic       go,      // Start one reset frame
  input  wire logic [5:0] npulse,  // Clock pulses inside the frame
  output logic            rst_n,   // Reset pin drive, active low
  output logic            sclk,    // Clock pin drive value
  output logic            sclk_oe, // Clock pin drive enable
  output logic            done     // Frame finished
);
  initial begin
    rst_n = 1'b1;
    sclk = 1'b1;
    sclk_oe = 1'b0;
    done = 1'b0;
  end
  // Link clock stands high outside the burst
  always @(posedge go) begin
    done = 1'b0;
    rst_n = 1'b0;
    sclk_oe = 1'b1;
    #100;
    repeat (npulse) begin
      sclk = 1'b0;
      #24;
      sclk = 1'b1;
      #24;
    end
    #100;
    rst_n = 1'b1;
    #60;
    sclk_oe = 1'b0;
    done = 1'b1;
  end
endmodule
`default_nettype wire

// [test/flash_program_protect_control_test.sv]
// Self-checking bench for the flash program/erase controller
`timescale 1ns/1ps
`default_nettype none
`include "fpp_map.vh"
module flash_program_protect_control_test;
  localparam [15:0] VU = 16'hFFFE;
  localparam [15:0] VS = 16'h1000;
  logic        clock, sys_rst, reg_wr, reg_rd, socket, go;
  logic [2:0]  reg_addr;
  logic [7:0]  reg_wdata, q;
  logic [5:0]  npulse;
  logic [11:0] a0, a1;
  logic [31:0] r;
  logic [5:0]  ent [5];
  logic [7:0]  mem [0:4095];
  int          num_errors, samples_checked, n1, i;
  wire [7:0]   reg_rdata;
  wire [15:0]  boot;
  wire         rst_n, t_clk, t_oe, p_o, p_oe, p_pu, comm, rc, busy, done;
  wire         mass, eblk, ewe;
  wire         pin = p_oe ? p_o : (t_oe ? t_clk : 1'b1); // Pull-up idle
  fpp_ctrl #(.VEC_USER(VU), .VEC_SYSMEM(VS)) dut (
    .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rst_pin_n(rst_n),
    .prog_serial_clock_pin_i(pin), .prog_serial_clock_pin_o(p_o),
    .prog_serial_clock_pin_oe(p_oe), .prog_serial_clock_pullup(p_pu),
    .socket_mode_pin(socket), .in_circuit_comm(comm),
    .rc_clock_forced(rc), .boot_vector_r(boot), .flash_busy(busy),
    .eeprom_mass_erase_r(mass), .eeprom_readout_block(eblk),
    .eeprom_write_enable(ewe));
  fpp_tool_model tool (.go(go), .npulse(npulse), .rst_n(rst_n),
    .sclk(t_clk), .sclk_oe(t_oe), .done(done));
  function automatic logic [1:0] ent_exp(input logic [5:0] k);
    return {k == `FPP_PULSES_RC || k == `FPP_PULSES_EXT, k == `FPP_PULSES_RC};
  endfunction
  task automatic report_and_stop;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  task automatic seek(input logic [11:0] a);
    wr(`FPP_REG_ADDR_HI, {4'h0, a[11:8]});
    wr(`FPP_REG_ADDR_LO, a[7:0]);
  endtask
  task automatic wait_idle;
    int k;
    repeat (3) @(posedge clock);
    #1;
    for (k = 0; k < 20000 && busy !== 1'b0; k++) @(posedge clock) #1;
    if (busy !== 1'b0) begin
      num_errors++;
      report_and_stop;
    end
  endtask
  task automatic keys;
    wr(`FPP_REG_FLASH_CTRL_STATUS, `FPP_KEY1);
    wr(`FPP_REG_FLASH_CTRL_STATUS, `FPP_KEY2);
  endtask
  // Refused operations must leave the array and expected copy untouched
  task automatic prog(input logic [11:0] a, input int n, input logic ok);
    int k;
    wr(`FPP_REG_STATUS, 8'h00);
    keys;
    wr(`FPP_REG_FLASH_CTRL_STATUS, 8'h02);
    seek(a);
    for (k = 0; k < n; k++) begin
      r = $urandom;
      wr(`FPP_REG_DATA, r[7:0]);
      if (ok) mem[a + k] = r[7:0];
    end
    wr(`FPP_REG_FLASH_CTRL_STATUS, 8'h03);
    wait_idle;
    rd(`FPP_REG_STATUS);
    chk({15'h0000, q[3]}, {15'h0000, !ok});
  endtask
  task automatic verify(input logic [11:0] a, input int n);
    int k;
    logic [11:0] x;
    for (k = 0; k < n; k++) begin
      x = a + 12'(k);
      seek(x);
      rd(`FPP_REG_DATA);
      chk({8'h00, q}, {8'h00, mem[x]});
    end
  endtask
  task automatic enter(input logic [5:0] k);
    int w;
    npulse <= k;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    for (w = 0; w < 1000 && done !== 1'b1; w++) @(posedge clock);
    if (done !== 1'b1) begin
      num_errors++;
      report_and_stop;
    end
    repeat (4) @(posedge clock);
    #1;
  endtask
  initial begin
    clock = 1'b0;
    // 200 MHz system clock; the tool model times its own pulse bursts
    forever #2.5 clock = ~clock;
  end
  initial begin
    sys_rst = 1'b1;
    {reg_wr, reg_rd, socket, go} = 4'h0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    npulse = 6'h00;
    num_errors = 0;
    samples_checked = 0;
    r = $urandom(84);
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    rd(`FPP_REG_FLASH_CTRL_STATUS);
    chk({8'h00, q}, {8'h00, `FPP_FLASH_CTRL_STATUS_RESET});
    chk({14'h0000, p_oe, p_pu}, 16'h0001);
    wr(`FPP_REG_PINCFG, 8'h03);
    chk({14'h0000, p_oe, p_o}, 16'h0003);
    enter(6'h00);
    chk({13'h0000, p_oe, p_pu, comm}, 16'h0002);
    r = $urandom;
    ent = '{6'h24, 6'h25, 6'(r % 35), `FPP_PULSES_RC, `FPP_PULSES_EXT};
    foreach (ent[j]) begin
      enter(ent[j]);
      chk({14'h0000, comm, rc}, {14'h0000, ent_exp(ent[j])});
      chk(boot, ent_exp(ent[j]) != 2'b00 ? VS : VU);
    end
    r = $urandom;
    a0 = {3'h0, r[3:0], 5'h00};
    a1 = {r[6:4] | 3'h1, r[10:7], 5'h00};
    n1 = int'(r[15:11]) + 1;
    prog(a0, 32, 1'b1);
    verify(a0, 32);
    prog(a1, n1, 1'b1);
    verify(a1, n1);
    keys;
    seek(a1);
    wr(`FPP_REG_FLASH_CTRL_STATUS, 8'h05);
    wait_idle;
    for (i = 512; i < 4096; i++) mem[i] = `FPP_ERASED;
    verify(a1, n1);
    verify(a0, 32);
    wr(`FPP_REG_FLASH_CTRL_STATUS, `FPP_KEY1);
    wr(`FPP_REG_FLASH_CTRL_STATUS, 8'h11);
    wr(`FPP_REG_FLASH_CTRL_STATUS, 8'h05);
    rd(`FPP_REG_FLASH_CTRL_STATUS);
    chk({7'h00, busy, q}, 16'h0000);
    enter(6'h00);
    prog(a0, 4, 1'b0);
    verify(a0, 32);
    prog(a1, 4, 1'b1);
    verify(a1, 4);
    socket <= 1'b1;
    repeat (4) @(posedge clock);
    wr(`FPP_REG_OPTION, 8'h05);
    rd(`FPP_REG_OPTION);
    chk({7'h00, eblk, q}, 16'h0105);
    prog(a1, 4, 1'b0);
    seek(a1);
    rd(`FPP_REG_DATA);
    chk({8'h00, q}, 16'h0000);
    wr(`FPP_REG_OPTION, 8'h00);
    rd(`FPP_REG_STATUS);
    chk({7'h00, ewe, q}, 16'h002B);
    wait_idle;
    for (i = 0; i < 4096; i++) mem[i] = `FPP_ERASED;
    verify(a0, 32);
    rd(`FPP_REG_OPTION);
    chk({8'h00, q}, 16'h0000);
    wr(`FPP_REG_OPTION, 8'h02);
    rd(`FPP_REG_OPTION);
    chk({7'h00, ewe, q}, 16'h0102);
    prog(a1, 4, 1'b0);
    wr(`FPP_REG_OPTION, 8'h00);
    rd(`FPP_REG_OPTION);
    chk({8'h00, q}, 16'h0002);
    verify(a1, 4);
    report_and_stop;
  end
endmodule
`default_nettype wire
